// *** logic/aeu_core.sv ***
// Add and execute unit: decode, operand fetch and execute of four ops
`timescale 1ns/1ps
module aeu_core
  import aeu_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_i,
  input  wire aeu_pkg::aeu_instr_t   instr_i,
  output logic                       ready_o,
  output logic                       done_o,
  output logic      [DATA_W-1:0]     acc_o,
  output aeu_pkg::aeu_flags_t        flags_o
);

  import aeu_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Add immediate ignores bit 8, so its shorter field is tested first
  function automatic aeu_op_t decode(input logic [INSTR_W-1:0] w);
    if (w[13:9] == OPC_ADD_IMM)
    begin
      decode = AEU_OP_ADD_IMM;
    end
    else if (w[13:8] == OPC_AND_IMM)
    begin
      decode = AEU_OP_AND_IMM;
    end
    else if (w[13:8] == OPC_ADD_REG)
    begin
      decode = AEU_OP_ADD_REG;
    end
    else if (w[13:8] == OPC_AND_REG)
    begin
      decode = AEU_OP_AND_REG;
    end
    else
    begin
      // Unlisted words fall through to no operation
      decode = AEU_OP_NONE;
    end
  endfunction

  // Register operand forms read the file and may write it back
  function automatic logic is_reg_op(input aeu_op_t op);
    is_reg_op = (op == AEU_OP_ADD_REG) || (op == AEU_OP_AND_REG);
  endfunction

  // Only the add forms touch carry and half carry
  function automatic logic is_add_op(input aeu_op_t op);
    is_add_op = (op == AEU_OP_ADD_IMM) || (op == AEU_OP_ADD_REG);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_EXEC} aeu_state_t;

  // Everything the unit remembers apart from the register file, in one flop bank
  typedef struct packed {
    aeu_state_t         st;
    aeu_op_t            op;
    logic [DATA_W-1:0]  imm;
    logic [ADDR_W-1:0]  addr;
    logic               dest;
    logic [DATA_W-1:0]  acc;
    aeu_flags_t         flags;
    logic               ready;
    logic               done;
  } aeu_core_state_t;

  aeu_core_state_t s_q;
  aeu_core_state_t s_d;

  logic [DATA_W-1:0] reg_rd;
  logic              wr_en;
  logic [DATA_W-1:0] wr_data;
  aeu_op_t           dec_op;
  logic              take;
  logic [DATA_W-1:0] imm_fld;
  logic [ADDR_W-1:0] addr_fld;
  logic              dest_fld;

  // ----------------------------------------------------------------
  // Accept
  // ----------------------------------------------------------------
  assign dec_op   = decode(instr_i.word);
  assign imm_fld  = instr_i.word[DATA_W-1:0];
  assign addr_fld = instr_i.word[ADDR_W-1:0];
  assign dest_fld = instr_i.word[DEST_BIT];
  // Words offered while busy, or that decode to nothing, are dropped
  assign take     = s_q.ready && instr_i.valid && (dec_op != AEU_OP_NONE);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Read is issued on accept so the operand arrives for the exec cycle
  aeu_regfile aeu_regfile_inst (
    .ref_clk_i (ref_clk_i),
    .rd_addr_i (addr_fld),
    .rd_data_o (reg_rd),
    .wr_en_i   (wr_en),
    .wr_addr_i (s_q.addr),
    .wr_data_i (wr_data)
  );

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] opnd;
  logic [DATA_W:0]   sum;
  logic [HALF_BIT:0] half;
  logic [DATA_W-1:0] res;
  logic              is_add;
  logic              is_reg;

  always_comb
  begin
    is_reg = is_reg_op(s_q.op);
    is_add = is_add_op(s_q.op);
    opnd   = is_reg ? reg_rd : s_q.imm;
    sum    = {1'b0, s_q.acc} + {1'b0, opnd};
    // Half carry from a separate add of the low nibbles
    half   = {1'b0, s_q.acc[HALF_BIT-1:0]} + {1'b0, opnd[HALF_BIT-1:0]};
    res    = is_add ? sum[DATA_W-1:0] : (s_q.acc & opnd);
  end

  // Lands at the end of exec, before any later take can read it
  // register write when destination bit set
  assign wr_en   = (s_q.st == ST_EXEC) && is_reg && s_q.dest;
  assign wr_data = res;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.ready = 1'b1;
        if (take)
        begin
          s_d.op    = dec_op;
          s_d.imm   = imm_fld;
          s_d.addr  = addr_fld;
          s_d.dest  = dest_fld;
          s_d.st    = ST_EXEC;
          // Busy for the one exec cycle only
          s_d.ready = 1'b0;
        end
      end
      ST_EXEC:
      begin
        // accumulator write for immediate forms, and for register forms when destination bit clear
        if (!is_reg || !s_q.dest)
        begin
          s_d.acc = res;
        end
        // Flags update for either destination
        // zero flag
        s_d.flags.zero = (res == '0);
        if (is_add)
        begin
          s_d.flags.carry           = sum[DATA_W];
          s_d.flags.half_carry_flag = half[HALF_BIT];
        end
        s_d.done  = 1'b1;
        s_d.ready = 1'b1;
        s_d.st    = ST_IDLE;
      end
      default:
      begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Register file is left alone; only this state clears
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.op    <= AEU_OP_NONE;
      s_q.acc   <= ACC_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Straight from the state flops, no logic after them
  assign ready_o = s_q.ready;
  assign done_o  = s_q.done;
  assign acc_o   = s_q.acc;
  assign flags_o = s_q.flags;

endmodule

// *** logic/aeu_pkg.sv ***
// Package for the add and execute unit: widths, opcodes, flag layout
package aeu_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned DEPTH   = 128;

  // ----------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned HALF_BIT = 4;

  // Opcode patterns on the upper bits of the word
  localparam logic [4:0] OPC_ADD_IMM = 5'h1F;  // 11 111x, bits 13:9
  localparam logic [5:0] OPC_AND_IMM = 6'h39;  // 11 1001, bits 13:8
  localparam logic [5:0] OPC_ADD_REG = 6'h07;  // 00 0111
  localparam logic [5:0] OPC_AND_REG = 6'h05;  // 00 0101

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AEU_OP_NONE,
    AEU_OP_ADD_IMM,
    AEU_OP_AND_IMM,
    AEU_OP_ADD_REG,
    AEU_OP_AND_REG
  } aeu_op_t;

  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
  } aeu_flags_t;

  typedef struct packed {
    logic              valid;
    logic [INSTR_W-1:0] word;
  } aeu_instr_t;

endpackage

// *** logic/aeu_regfile.sv ***
// Data register file: 128 x 8, registered read, one write port
`timescale 1ns/1ps
module aeu_regfile
  import aeu_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i
);

  // No reset: contents are undefined until written, as in a RAM
  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// *** tb/add_and_execute_unit_bench.sv ***
// Directed bench for the add and execute unit
`timescale 1ns/1ps
module add_and_execute_unit_bench;
  import aeu_pkg::*;
  logic       ref_clk_i = 1'b0;
  logic       rst_i;
  aeu_instr_t instr;
  logic       ready_o, done_o;
  logic [7:0] acc_o;
  aeu_flags_t flags_o;
  int         err_count, total_checks, cyc;

  aeu_core aeu_core_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr),
    .ready_o(ready_o), .done_o(done_o), .acc_o(acc_o), .flags_o(flags_o));

  always #4 ref_clk_i = ~ref_clk_i;

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Drive on the rising edge, look at outputs on the falling edge
  task automatic exec(input logic [13:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    instr <= '{1'b1, wd};
    @(negedge ref_clk_i);
    chk({6'h00, ready_o, done_o}, 8'h02);
    while (ready_o !== 1'b1 && n < 8)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    instr.valid <= 1'b0;
    @(negedge ref_clk_i);
    chk({6'h00, ready_o, done_o}, 8'h00);
    @(negedge ref_clk_i);
    chk({6'h00, ready_o, done_o}, 8'h03);
  endtask

  task automatic t_imm();
    exec({6'h3E, 8'hF8});
    exec({6'h3F, 8'h08});
    chk(acc_o, 8'h00);
    chk({5'h00, flags_o}, 8'h07);
    exec({6'h3E, 8'hF8});
    exec({6'h3E, 8'hA3});
    exec({6'h39, 8'h5F});
    chk(acc_o, 8'h1B);
    chk({5'h00, flags_o}, 8'h04);
    exec({6'h39, 8'h00});
    chk({5'h00, flags_o}, 8'h05);
  endtask

  task automatic t_reg();
    exec({6'h05, 8'hFF});
    exec({6'h3E, 8'hC2});
    exec({6'h07, 8'hFF});
    chk(acc_o, 8'hC2);
    exec({6'h3E, 8'h55});
    exec({6'h07, 8'h7F});
    chk(acc_o, 8'hD9);
    chk({5'h00, flags_o}, 8'h00);
    exec({6'h05, 8'hFF});
    exec({6'h07, 8'h7F});
    chk(acc_o, 8'h99);
    chk({5'h00, flags_o}, 8'h04);
    exec({6'h05, 8'h7F});
    chk(acc_o, 8'h80);
  endtask

  task automatic t_bad();
    @(posedge ref_clk_i);
    instr <= '{1'b1, 14'h0000};
    repeat (4) @(negedge ref_clk_i);
    chk({6'h00, ready_o, done_o}, 8'h02);
    chk(acc_o, 8'h80);
    chk({5'h00, flags_o}, 8'h04);
    @(posedge ref_clk_i);
    instr.valid <= 1'b0;
  endtask

  // Mid-run reset, then a first add right after release
  task automatic t_rst();
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(negedge ref_clk_i);
    chk({6'h00, ready_o, done_o}, 8'h00);
    chk(acc_o, 8'h00);
    chk({5'h00, flags_o}, 8'h00);
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    exec({6'h3E, 8'h15});
    chk(acc_o, 8'h15);
    exec({6'h3E, 8'h10});
    chk(acc_o, 8'h25);
    chk({5'h00, flags_o}, 8'h00);
  endtask

  task automatic final_report();
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      final_report();
    end
  end

  initial
  begin
    rst_i = 1'b1;
    instr = '0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_imm();
    t_reg();
    t_bad();
    t_rst();
    final_report();
  end
endmodule

bind aeu_core aeu_core_asserts aeu_core_asserts_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .instr_i(instr_i), .ready_o(ready_o), .done_o(done_o), .acc_o(acc_o), .flags_o(flags_o));

// *** tb/aeu_core_asserts.sv ***
// Port checker for the add and execute unit
`timescale 1ns/1ps
module aeu_core_asserts
  import aeu_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  input  wire aeu_pkg::aeu_instr_t instr_i,
  input  wire logic               ready_o,
  input  wire logic               done_o,
  input  wire logic [DATA_W-1:0]  acc_o,
  input  wire aeu_pkg::aeu_flags_t flags_o
);
  logic [13:0] w;
  logic [8:0]  s;
  logic [4:0]  h;
  logic        t;
  assign w = instr_i.word;
  assign t = ready_o && instr_i.valid;
  assign s = acc_o + w[7:0];
  assign h = acc_o[3:0] + w[3:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_add_imm_sum: assert property (t && w[13:9] == 5'h1F |-> ##2 acc_o == $past(s[7:0], 2))
    else $error("add immediate sum wrong");
  a_add_flags: assert property (t && w[13:9] == 5'h1F |-> ##2
    flags_o == {$past(s[8], 2), $past(h[4], 2), $past(s[7:0], 2) == 8'h00})
    else $error("add immediate flags wrong");
  a_and_imm_keep: assert property (t && w[13:8] == 6'h39 |-> ##2
    acc_o == $past(acc_o & w[7:0], 2) && $stable(flags_o[2:1]))
    else $error("and immediate result wrong");
  a_reg_dest_acc: assert property (t && w[13:8] inside {6'h05, 6'h07} && w[7]
    |-> ##2 acc_o == $past(acc_o, 2))
    else $error("register destination changed accumulator");
  a_reg_zero: assert property (t && w[13:8] inside {6'h05, 6'h07} && !w[7]
    |-> ##2 flags_o.zero == (acc_o == 8'h00))
    else $error("register form zero flag wrong");
  a_and_reg_keep: assert property (t && w[13:8] == 6'h05 |-> ##2 $stable(flags_o[2:1]))
    else $error("and register touched carry");
  a_done_time: assert property (t && (w[13:9] == 5'h1F || w[13:8] inside {6'h39, 6'h07, 6'h05})
    |=> !ready_o && !done_o ##1 done_o && ready_o ##1 !done_o)
    else $error("completion timing wrong");
endmodule
